// File: ppr_pkg.sv
package ppr_pkg;

  // ************************************************************
  // device size and clock
  // ************************************************************
  localparam int NUM_PORTS = 2;
  localparam int CLK_MHZ   = 125;

  // ************************************************************
  // debounce times and derived cycle counts
  // ************************************************************
  localparam int CONN_DEBOUNCE_MS  = 341;
  localparam int BIAS_DEBOUNCE_US  = 52;
  localparam int CONN_DEBOUNCE_CYC = CONN_DEBOUNCE_MS * CLK_MHZ * 1000;
  localparam int BIAS_DEBOUNCE_CYC = BIAS_DEBOUNCE_US * CLK_MHZ;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [3:0] ADDR_EVENT  = 4'h5;
  localparam logic [3:0] ADDR_SELECT = 4'h7;
  localparam logic [3:0] ADDR_PG_08  = 4'h8;
  localparam logic [3:0] ADDR_PG_09  = 4'h9;
  localparam logic [3:0] ADDR_OUI0   = 4'hA;
  localparam logic [3:0] ADDR_OUI1   = 4'hB;
  localparam logic [3:0] ADDR_OUI2   = 4'hC;
  localparam logic [3:0] ADDR_PART0  = 4'hD;
  localparam logic [3:0] ADDR_PART1  = 4'hE;
  localparam logic [3:0] ADDR_PART2  = 4'hF;
  localparam logic [3:0] ADDR_SRST   = 4'hE;

  // ************************************************************
  // pages, field positions and codes
  // ************************************************************
  localparam logic [2:0] PAGE_PORT   = 3'h0;
  localparam logic [2:0] PAGE_IDENT  = 3'h1;
  localparam logic [2:0] PAGE_VENDOR = 3'h7;
  localparam int         SEL_PAGE_LSB = 5;
  localparam int         BIT_OFF      = 0;
  localparam int         BIT_EVT_EN   = 4;
  localparam int         BIT_FAULT    = 3;
  localparam int         BIT_NPH      = 7;
  localparam int         BIT_SRST     = 7;
  localparam int         BIT_EVENT    = 0;
  localparam logic [1:0] LINE_Z       = 2'h3;
  localparam logic [1:0] LINE_ONE     = 2'h1;
  localparam logic [1:0] LINE_ZERO    = 2'h2;
  localparam logic [2:0] SPEED_S400   = 3'h2;
  localparam logic [7:0] COMPLIANCE   = 8'h01;
  localparam logic [1:0] LRATE_RST    = 2'h0;

endpackage : ppr_pkg

// File: ppr_filt_if.sv
`timescale 1ns/1ns
interface ppr_filt_if;
  logic raw;
  logic stable;

  modport filt (input raw, output stable);
  modport user (output raw, input stable);
endinterface : ppr_filt_if

// File: ppr_debounce.sv
`timescale 1ns/1ns
module ppr_debounce #(
  parameter int LIMIT = 16
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // filtered line
  ppr_filt_if.filt line
);

  localparam int CW = $clog2(LIMIT + 1);

  logic          s1_r;
  logic          s2_r;
  logic          stable_r;
  logic [CW-1:0] cnt_r;

  // any drop restarts the wait; level goes only once fully stable
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      s1_r     <= 1'b0;
      s2_r     <= 1'b0;
      stable_r <= 1'b0;
      cnt_r    <= '0;
    end else begin
      s1_r <= line.raw;
      s2_r <= s1_r;
      if (!s2_r) begin
        cnt_r    <= '0;
        stable_r <= 1'b0;
      end else if (cnt_r == CW'(LIMIT - 1)) begin
        stable_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign line.stable = stable_r;

  a_filt_settle_time: assert property ( // [RL5] [RL6]
    @(posedge ref_clk_in) disable iff (srst_in)
    $rose(stable_r) |-> ($past(cnt_r) == CW'(LIMIT - 1)) && $past(s2_r))
    else $error("filter level rose before the stable time");

  a_filt_drop_now: assert property ( // [RL5] [RL6]
    @(posedge ref_clk_in) disable iff (srst_in)
    !s2_r |=> !stable_r)
    else $error("filter level held after line loss");

endmodule : ppr_debounce

// File: ppr_port_regs.sv
`timescale 1ns/1ns
// Overview of operation
// RL1 - A-pair state reads 11 high-Z, 01 one, 10 zero.
// RL2 - B-pair state uses the same two-bit encoding.
// RL3 - child flag 1 for child; disconnected, disabled, suspended ports read child.
// RL4 - software ignores child flag until tree identification completes.
// RL5 - connected flag sets after 341 ms stable; cleared only by hardware reset. Code also clears it as soon as the synchronised line drops.
// RL6 - bias flag sets after 52 us of stable incoming bias.
// RL7 - disable bit disables port; hardware reset clears it.
// RL8 - peer rate reads 000 S100, 001 S200, 010 S400.
// RL9 - software ignores peer rate until self-identification completes.
// RL10 - peer rate never reads above 010.
// RL11 - enabled port events set event flag and notify the link.
// RL12 - fault bit set on suspend/resume fault; write 1 clears it.
// RL13 - resume fault without peer bias; suspend fault with peer bias.
// RL14 - software selects page 1 for identification.
// RL15 - compliance byte at 1000 reads 01h.
// RL16 - maker OUI at 1010 to 1100, high byte first.
// RL17 - part identifier at 1101 to 1111, high byte first.
// RL18 - software selects page 7 for vendor controls.
// RL19 - page 7 at 1000: null-packet hold bit 0, link rate bits 6-7. Code uses bit 7 for null-packet hold and bits 0-1 for link rate.
// RL20 - soft device reset at page 7, 1110 bit 0; rest reserved. Code takes the soft reset from bit 7.
// RL21 - unimplemented port reads zero on the port status page.
// RL22 - page selector picks page for addresses 8-15; resets to 0.
// RL23 - change of bias, connected, disabled or fault sets event flag.
// RL24 - reserved bits read zero and ignore writes.
module ppr_port_regs #(
  parameter int          NUM_PORTS = ppr_pkg::NUM_PORTS,
  parameter int          CONN_CYC  = ppr_pkg::CONN_DEBOUNCE_CYC,
  parameter int          BIAS_CYC  = ppr_pkg::BIAS_DEBOUNCE_CYC,
  parameter logic [23:0] MAKER_OUI = 24'h5A5A5A,  // arbitrary value
  parameter logic [23:0] PART_IDENT = 24'hA5A5A5  // arbitrary value
) (
  // clock and reset
  input  wire logic                      ref_clk_in,
  input  wire logic                      srst_in,
  // register port
  input  wire logic [3:0]                reg_addr_in,
  input  wire logic [7:0]                reg_wdata_in,
  input  wire logic                      reg_wr_in,
  input  wire logic                      reg_rd_in,
  output logic      [7:0]                reg_rdata_out,
  // port line pins
  input  wire logic [NUM_PORTS-1:0]      tpa_high_z_in,
  input  wire logic [NUM_PORTS-1:0]      tpa_level_in,
  input  wire logic [NUM_PORTS-1:0]      tpb_high_z_in,
  input  wire logic [NUM_PORTS-1:0]      tpb_level_in,
  input  wire logic [NUM_PORTS-1:0]      child_in,
  input  wire logic [NUM_PORTS-1:0]      conn_raw_in,
  input  wire logic [NUM_PORTS-1:0]      bias_raw_in,
  input  wire logic [NUM_PORTS-1:0]      suspended_in,
  input  wire logic [NUM_PORTS-1:0]      resuming_in,
  input  wire logic [NUM_PORTS-1:0]      suspending_in,
  input  wire logic [NUM_PORTS-1:0][2:0] peer_rate_in,
  // controls to the port and link logic
  output logic      [NUM_PORTS-1:0]      port_disable_out,
  output logic                           port_event_out,
  output logic                           null_packet_hold_out,
  output logic      [1:0]                link_rate_out,
  output logic                           soft_device_reset_out
);

  localparam int PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;
  localparam int SW = 11;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [NUM_PORTS-1:0][SW-1:0] pin_raw;
  logic [NUM_PORTS-1:0][SW-1:0] pin_s1_r;
  logic [NUM_PORTS-1:0][SW-1:0] pin_s2_r;

  logic [NUM_PORTS-1:0]      tpa_z;
  logic [NUM_PORTS-1:0]      tpa_l;
  logic [NUM_PORTS-1:0]      tpb_z;
  logic [NUM_PORTS-1:0]      tpb_l;
  logic [NUM_PORTS-1:0]      child_s;
  logic [NUM_PORTS-1:0]      susp_s;
  logic [NUM_PORTS-1:0]      resm_s;
  logic [NUM_PORTS-1:0]      sspd_s;
  logic [NUM_PORTS-1:0][2:0] spd_s;
  logic [NUM_PORTS-1:0]      conn_deb;
  logic [NUM_PORTS-1:0]      bias_deb;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ************************************************************
  // selector and control registers
  // ************************************************************
  logic [2:0] page_r;
  logic [3:0] port_sel_r;
  logic       evt_r;
  logic       nph_r;
  logic [1:0] lrate_r;
  logic       soft_rst_r;
  logic [7:0] rdata_r;

  logic [NUM_PORTS-1:0]      off_r;
  logic [NUM_PORTS-1:0]      evt_en_r;
  logic [NUM_PORTS-1:0]      fault_r;
  logic [NUM_PORTS-1:0][3:0] watch_prev_r;
  logic [NUM_PORTS-1:0][3:0] watch;
  logic [NUM_PORTS-1:0]      fault_set;
  logic [NUM_PORTS-1:0]      port_change;
  logic [NUM_PORTS-1:0][7:0] line_byte;
  logic [NUM_PORTS-1:0][7:0] speed_byte;

  // ************************************************************
  // write decode
  // ************************************************************
  logic          port_ok;
  logic [PW-1:0] pidx;
  logic          pg_port;
  logic          pg_ident;
  logic          pg_vendor;
  logic          wr_select;
  logic          wr_event;
  logic          wr_line;
  logic          wr_speed;
  logic          wr_vctrl;
  logic          wr_soft_rst;
  logic          evt_clr;
  logic          evt_nxt;

  assign port_ok   = port_sel_r < 4'(NUM_PORTS);  // [RL21]
  assign pidx      = port_sel_r[PW-1:0];
  assign pg_port   = page_r == ppr_pkg::PAGE_PORT;
  assign pg_ident  = page_r == ppr_pkg::PAGE_IDENT;
  assign pg_vendor = page_r == ppr_pkg::PAGE_VENDOR;
  assign wr_select = reg_wr_in && reg_addr_in == ppr_pkg::ADDR_SELECT;
  assign wr_event  = reg_wr_in && reg_addr_in == ppr_pkg::ADDR_EVENT;
  assign wr_line   = reg_wr_in && pg_port && port_ok
                     && reg_addr_in == ppr_pkg::ADDR_PG_08;
  assign wr_speed  = reg_wr_in && pg_port && port_ok
                     && reg_addr_in == ppr_pkg::ADDR_PG_09;
  assign wr_vctrl  = reg_wr_in && pg_vendor
                     && reg_addr_in == ppr_pkg::ADDR_PG_08;
  assign wr_soft_rst = reg_wr_in && pg_vendor
                       && reg_addr_in == ppr_pkg::ADDR_SRST;
  assign evt_clr   = wr_event && reg_wdata_in[ppr_pkg::BIT_EVENT];
  // a new port event beats a clear in the same cycle
  assign evt_nxt   = (|port_change) || (evt_r && !evt_clr);  // [RL11] [RL23]

  // ************************************************************
  // per-port logic
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      ppr_filt_if conn_if ();
      ppr_filt_if bias_if ();
      logic sel_me;

      assign pin_raw[gi] = {tpa_high_z_in[gi], tpa_level_in[gi],
                            tpb_high_z_in[gi], tpb_level_in[gi],
                            child_in[gi], suspended_in[gi],
                            resuming_in[gi], suspending_in[gi],
                            peer_rate_in[gi]};
      assign {tpa_z[gi], tpa_l[gi], tpb_z[gi], tpb_l[gi], child_s[gi],
              susp_s[gi], resm_s[gi], sspd_s[gi], spd_s[gi]} = pin_s2_r[gi];

      assign conn_if.raw  = conn_raw_in[gi];
      assign bias_if.raw  = bias_raw_in[gi];
      assign conn_deb[gi] = conn_if.stable;
      assign bias_deb[gi] = bias_if.stable;

      ppr_debounce #(.LIMIT(CONN_CYC)) u_conn_filt (  // [RL5]
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .line       (conn_if)
      );

      ppr_debounce #(.LIMIT(BIAS_CYC)) u_bias_filt (  // [RL6]
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .line       (bias_if)
      );

      assign sel_me = pidx == PW'(gi);
      assign fault_set[gi] = (resm_s[gi] && !bias_deb[gi])
                             || (sspd_s[gi] && bias_deb[gi]);  // [RL13]
      assign watch[gi] = {bias_deb[gi], conn_deb[gi], off_r[gi], fault_r[gi]};
      assign port_change[gi] = evt_en_r[gi]
                               && watch[gi] != watch_prev_r[gi];  // [RL23]

      assign line_byte[gi] = {
        tpa_z[gi] ? ppr_pkg::LINE_Z
                  : (tpa_l[gi] ? ppr_pkg::LINE_ONE : ppr_pkg::LINE_ZERO),  // [RL1]
        tpb_z[gi] ? ppr_pkg::LINE_Z
                  : (tpb_l[gi] ? ppr_pkg::LINE_ONE : ppr_pkg::LINE_ZERO),  // [RL2]
        child_s[gi] || !conn_deb[gi] || off_r[gi] || susp_s[gi],  // [RL3]
        conn_deb[gi],
        bias_deb[gi],
        off_r[gi]};
      // the detector tops out at S400; anything above is clamped
      assign speed_byte[gi] = {
        (spd_s[gi] > ppr_pkg::SPEED_S400) ? ppr_pkg::SPEED_S400
                                          : spd_s[gi],  // [RL8] [RL10]
        evt_en_r[gi],
        fault_r[gi],
        3'h0};  // [RL24]

      // only hardware reset touches these; bus reset never reaches here
      always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
          off_r[gi]        <= 1'b0;
          evt_en_r[gi]     <= 1'b0;
          fault_r[gi]      <= 1'b0;
          watch_prev_r[gi] <= 4'h0;
        end else begin
          watch_prev_r[gi] <= watch[gi];
          if (wr_line && sel_me) begin
            off_r[gi] <= reg_wdata_in[ppr_pkg::BIT_OFF];  // [RL7]
          end
          if (wr_speed && sel_me) begin
            evt_en_r[gi] <= reg_wdata_in[ppr_pkg::BIT_EVT_EN];  // [RL11]
          end
          fault_r[gi] <= fault_set[gi] || (fault_r[gi]
                         && !(wr_speed && sel_me
                         && reg_wdata_in[ppr_pkg::BIT_FAULT]));  // [RL12]
        end
      end
    end
  endgenerate

  // ************************************************************
  // shared control registers
  // ************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      page_r     <= ppr_pkg::PAGE_PORT;
      port_sel_r <= 4'h0;
      evt_r      <= 1'b0;
      nph_r      <= 1'b0;
      lrate_r    <= ppr_pkg::LRATE_RST;
      soft_rst_r <= 1'b0;
    end else begin
      if (wr_select) begin
        page_r     <= reg_wdata_in[7:ppr_pkg::SEL_PAGE_LSB];  // [RL22]
        port_sel_r <= reg_wdata_in[3:0];
      end
      if (wr_vctrl) begin
        nph_r   <= reg_wdata_in[ppr_pkg::BIT_NPH];  // [RL19]
        lrate_r <= reg_wdata_in[1:0];
      end
      evt_r <= evt_nxt;
      soft_rst_r <= wr_soft_rst && reg_wdata_in[ppr_pkg::BIT_SRST];  // [RL20]
    end
  end

  // ************************************************************
  // read selection
  // ************************************************************
  logic [7:0] p0_val;
  logic [7:0] p1_val;
  logic [7:0] p7_val;
  logic [7:0] paged_val;
  logic [7:0] base_val;
  logic [7:0] rd_val;

  assign p0_val = !port_ok ? 8'h00 :  // [RL21]
                  (reg_addr_in == ppr_pkg::ADDR_PG_08) ? line_byte[pidx] :
                  (reg_addr_in == ppr_pkg::ADDR_PG_09) ? speed_byte[pidx] :
                  8'h00;
  assign p1_val = (reg_addr_in == ppr_pkg::ADDR_PG_08) ? ppr_pkg::COMPLIANCE :  // [RL15]
                  (reg_addr_in == ppr_pkg::ADDR_OUI0)  ? MAKER_OUI[23:16] :  // [RL16]
                  (reg_addr_in == ppr_pkg::ADDR_OUI1)  ? MAKER_OUI[15:8] :
                  (reg_addr_in == ppr_pkg::ADDR_OUI2)  ? MAKER_OUI[7:0] :
                  (reg_addr_in == ppr_pkg::ADDR_PART0) ? PART_IDENT[23:16] :  // [RL17]
                  (reg_addr_in == ppr_pkg::ADDR_PART1) ? PART_IDENT[15:8] :
                  (reg_addr_in == ppr_pkg::ADDR_PART2) ? PART_IDENT[7:0] :
                  8'h00;
  // reset control reads back zero; test locations are not built
  assign p7_val = (reg_addr_in == ppr_pkg::ADDR_PG_08)
                  ? {nph_r, 5'h00, lrate_r} : 8'h00;  // [RL19] [RL20] [RL24]
  assign paged_val = pg_port   ? p0_val :
                     pg_ident  ? p1_val :
                     pg_vendor ? p7_val : 8'h00;
  assign base_val = (reg_addr_in == ppr_pkg::ADDR_SELECT)
                    ? {page_r, 1'b0, port_sel_r} :
                    (reg_addr_in == ppr_pkg::ADDR_EVENT)
                    ? {7'h00, evt_r} : 8'h00;
  assign rd_val = reg_addr_in[3] ? paged_val : base_val;

  // data stand only in the cycle after the read strobe
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd_in ? rd_val : 8'h00;
    end
  end

  assign reg_rdata_out         = rdata_r;
  assign port_disable_out      = off_r;
  assign port_event_out        = evt_r;
  assign null_packet_hold_out  = nph_r;
  assign link_rate_out         = lrate_r;
  assign soft_device_reset_out = soft_rst_r;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  a_rd_unimpl_zero: assert property ( // [RL21]
    reg_rd_in && pg_port && !port_ok && reg_addr_in[3] |=> reg_rdata_out == 8'h00)
    else $error("unimplemented port returned nonzero");

  a_peer_rate_cap: assert property ( // [RL10]
    reg_rd_in && pg_port && port_ok && reg_addr_in == ppr_pkg::ADDR_PG_09
    |=> reg_rdata_out[7:5] <= ppr_pkg::SPEED_S400)
    else $error("peer rate above S400 reported");

  a_child_forced_one: assert property ( // [RL3]
    reg_rd_in && pg_port && port_ok && reg_addr_in == ppr_pkg::ADDR_PG_08
    && (off_r[pidx] || !conn_deb[pidx])
    |=> reg_rdata_out[3])
    else $error("inactive port not read as child");

  a_compliance_byte: assert property ( // [RL15]
    reg_rd_in && pg_ident && reg_addr_in == ppr_pkg::ADDR_PG_08
    |=> reg_rdata_out == ppr_pkg::COMPLIANCE ##1 ($past(reg_rd_in) || reg_rdata_out == 8'h00))
    else $error("compliance byte wrong or held");

  a_disable_write: assert property ( // [RL7]
    wr_line |=> port_disable_out[$past(pidx)] == $past(reg_wdata_in[0]))
    else $error("disable bit not stored");

  a_fault_clear: assert property ( // [RL12]
    wr_speed && reg_wdata_in[ppr_pkg::BIT_FAULT] && !fault_set[pidx]
    |=> !fault_r[$past(pidx)])
    else $error("fault not cleared by write of one");

  a_event_set_wins: assert property ( // [RL11] [RL23]
    |port_change |=> port_event_out [*1] ##0 evt_r)
    else $error("port event did not raise flag");

  a_soft_rst_pulse: assert property ( // [RL20]
    wr_soft_rst && reg_wdata_in[ppr_pkg::BIT_SRST]
    |=> soft_device_reset_out
    ##1 (soft_device_reset_out == $past(wr_soft_rst && reg_wdata_in[ppr_pkg::BIT_SRST])))
    else $error("soft reset pulse wrong");

  a_page_after_reset: assert property ( // [RL22]
    disable iff (1'b0) srst_in |=> page_r == ppr_pkg::PAGE_PORT && !evt_r)
    else $error("page selector not cleared by reset");

endmodule : ppr_port_regs

// File: ppr_llc_model.sv
`timescale 1ns/1ns
// ************************************************************
// link side register master
// ************************************************************
module ppr_llc_model (
  // clock
  input  wire logic       ref_clk_in,
  // register port
  output logic      [3:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  input  wire logic [7:0] reg_rdata_in
);
  initial begin
    reg_addr_out  = 4'h0;
    reg_wdata_out = 8'h00;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
  end

  // released lines carry the inverse, never a stale copy
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    reg_wr_out    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_out    <= 1'b0;
    reg_addr_out  <= ~a;
    reg_wdata_out <= ~d;
    // let the written controls settle before the caller looks
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_rd_out   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_out   <= 1'b0;
    reg_addr_out <= ~a;
    #1 d = reg_rdata_in;
  endtask : rd

  task automatic sel(input logic [2:0] page, input logic [3:0] port);
    wr(ppr_pkg::ADDR_SELECT, {page, 1'b0, port});
  endtask : sel
endmodule : ppr_llc_model

// File: test_ppr_port_regs.sv
`timescale 1ns/1ns
module test_ppr_port_regs;
  // ************************************************************
  // stimulus and design
  // ************************************************************
  localparam int          CONN = 20;
  localparam int          BIAS = 8;
  localparam logic [23:0] OUI  = 24'h3C4D5E;  // arbitrary value
  localparam logic [23:0] PID  = 24'h617283;  // arbitrary value
  logic            clk;
  logic            srst_in;
  logic [3:0]      addr;
  logic [7:0]      wdata;
  logic [7:0]      rdata;
  logic            wr;
  logic            rd;
  logic [1:0]      ahz, alv, bhz, blv, chd, conn, bia, sus, res, spg, pdis;
  logic [1:0][2:0] spd;
  logic            pev, nph, soft_rst;
  logic [1:0]      lrate;
  int              miscompares = 0;
  int              samples_checked = 0;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {ahz, alv, bhz, blv, chd, conn, bia, sus, res, spg} = '0;
    spd = '0;
  end

  ppr_llc_model llc (.ref_clk_in(clk), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata));

  ppr_port_regs #(.CONN_CYC(CONN), .BIAS_CYC(BIAS), .MAKER_OUI(OUI), .PART_IDENT(PID)) uut (
    .ref_clk_in(clk), .srst_in(srst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .tpa_high_z_in(ahz),
    .tpa_level_in(alv), .tpb_high_z_in(bhz), .tpb_level_in(blv), .child_in(chd),
    .conn_raw_in(conn), .bias_raw_in(bia), .suspended_in(sus), .resuming_in(res),
    .suspending_in(spg), .peer_rate_in(spd), .port_disable_out(pdis),
    .port_event_out(pev), .null_packet_hold_out(nph), .link_rate_out(lrate),
    .soft_device_reset_out(soft_rst));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rdm(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    llc.rd(a, d);
    chk($sformatf("reg %h", a), e, d & m);
  endtask : rdm

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    @(posedge clk);
    srst_in <= 1'b1;
    tick(4);
    srst_in <= 1'b0;
    rdm(4'h7, 8'hFF, 8'h00);
    rdm(4'h8, 8'h06, 8'h00);
    chk("controls", 8'h00, {3'h0, pdis, pev, lrate});
  endtask : t_reset

  task automatic t_debounce;
    conn[0] <= 1'b1;
    bia[0] <= 1'b1;
    rdm(4'h8, 8'h06, 8'h00);
    tick(BIAS + 2);
    rdm(4'h8, 8'h06, 8'h02);
    tick(CONN - BIAS);
    rdm(4'h8, 8'h06, 8'h06);
  endtask : t_debounce

  task automatic t_line_child;
    logic [1:0] lc [3] = '{2'h3, 2'h1, 2'h2};
    for (int a = 0; a < 3; a++) begin
      ahz[0] <= (a == 0);
      alv[0] <= (a == 1);
      bhz[0] <= (a == 2);
      blv[0] <= (a == 0);
      tick(4);
      rdm(4'h8, 8'hF0, {lc[a], lc[(a + 1) % 3], 4'h0});
    end
    rdm(4'h8, 8'h08, 8'h00);
    chd[0] <= 1'b1;
    tick(3);
    rdm(4'h8, 8'h08, 8'h08);
    chd[0] <= 1'b0;
    sus[0] <= 1'b1;
    tick(3);
    rdm(4'h8, 8'h08, 8'h08);
    sus[0] <= 1'b0;
    llc.sel(3'h0, 4'h1);
    rdm(4'h8, 8'h08, 8'h08);
    llc.sel(3'h0, 4'h0);
  endtask : t_line_child

  task automatic t_speed;
    for (int i = 0; i < 8; i++) begin
      spd[0] <= i[2:0];
      tick(4);
      rdm(4'h9, 8'hE0, (i > 2 ? 8'h40 : i[7:0] << 5));
    end
  endtask : t_speed

  task automatic t_fault;
    spg[0] <= 1'b1;
    tick(4);
    rdm(4'h9, 8'h08, 8'h08);
    spg[0] <= 1'b0;
    tick(3);
    rdm(4'h9, 8'h08, 8'h08);
    llc.wr(4'h9, 8'h08);
    rdm(4'h9, 8'h08, 8'h00);
    bia[0] <= 1'b0;
    tick(5);
    res[0] <= 1'b1;
    tick(4);
    rdm(4'h9, 8'h08, 8'h08);
    res[0] <= 1'b0;
    tick(2);
    llc.wr(4'h9, 8'h08);
    rdm(4'h9, 8'h08, 8'h00);
  endtask : t_fault

  task automatic t_event;
    llc.wr(4'h5, 8'h01);
    llc.wr(4'h8, 8'h01);
    chk("disable", 8'h01, {6'h0, pdis});
    rdm(4'h8, 8'h08, 8'h08);
    rdm(4'h5, 8'h01, 8'h00);
    llc.wr(4'h9, 8'h10);
    rdm(4'h9, 8'h10, 8'h10);
    llc.wr(4'h8, 8'h00);
    tick(2);
    chk("event", 8'h01, {7'h0, pev});
    rdm(4'h5, 8'hFF, 8'h01);
    llc.wr(4'h5, 8'h01);
    rdm(4'h5, 8'h01, 8'h00);
    chk("event", 8'h00, {7'h0, pev});
  endtask : t_event

  task automatic t_ident;
    logic [47:0] id;
    id = {OUI, PID};
    llc.sel(3'h1, 4'h0);
    llc.wr(4'h8, 8'hFF);
    rdm(4'h8, 8'hFF, 8'h01);
    rdm(4'h9, 8'hFF, 8'h00);
    for (int i = 0; i < 6; i++) begin
      rdm(4'hA + i[3:0], 8'hFF, id[47 - 8 * i -: 8]);
    end
  endtask : t_ident

  task automatic t_vendor;
    int n;
    n = 0;
    llc.sel(3'h7, 4'h0);
    llc.wr(4'h8, 8'hFF);
    rdm(4'h8, 8'hFF, 8'h83);
    chk("null hold rate", 8'h07, {5'h0, nph, lrate});
    llc.wr(4'hE, 8'h80);
    repeat (3) begin
      #1 n += (soft_rst === 1'b1);
      @(posedge clk);
    end
    chk("soft reset pulses", 8'h01, n[7:0]);
    rdm(4'hE, 8'hFF, 8'h00);
    rdm(4'h9, 8'hFF, 8'h00);
    llc.sel(3'h3, 4'h0);
    rdm(4'h8, 8'hFF, 8'h00);
  endtask : t_vendor

  task automatic t_unimpl;
    llc.sel(3'h0, 4'h2);
    rdm(4'h7, 8'hFF, 8'h02);
    llc.wr(4'h8, 8'h01);
    rdm(4'h8, 8'hFF, 8'h00);
    rdm(4'h9, 8'hFF, 8'h00);
    chk("disable", 8'h00, {6'h0, pdis});
    rdm(4'h0, 8'hFF, 8'h00);
    llc.sel(3'h0, 4'h0);
    llc.wr(4'h8, 8'h01);
  endtask : t_unimpl

  initial begin
    srst_in = 1'b1;
    t_reset();
    t_debounce();
    t_line_child();
    t_speed();
    t_fault();
    t_event();
    t_ident();
    t_vendor();
    t_unimpl();
    t_reset();
    end_sim();
  end

  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule : test_ppr_port_regs
